// file: hw/scsc_pkg.sv
// Purpose: shared constants and types for the system clock switch control
// Assumes: 40 MHz core clock, 8-bit register port with two registers
// Notes: oscillator source order matches the bit order of the oscillator level vector
package scsc_pkg;

    // register port
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_STAT = 2'h1;

    // oscillator_control_reg fields
    localparam int CTL_PLL_BIT = 7;
    localparam int CTL_FSEL_LSB = 3;
    localparam int CTL_SCS_LSB = 0;
    localparam logic FSEL_PLL_RST = 1'h0;
    localparam logic [3:0] FSEL_RST = 4'h7;
    localparam logic [1:0] SCS_RST = 2'h0;

    // oscillator_status_reg fields
    localparam int STAT_SEC_BIT = 7;
    localparam int STAT_PLL_BIT = 6;
    localparam int STAT_DONE_BIT = 5;
    localparam int STAT_HF_BIT = 4;
    localparam int STAT_MF_BIT = 2;
    localparam int STAT_LF_BIT = 1;

    // source select codes and frequency select codes
    localparam logic [1:0] SCS_CONFIG = 2'h0;
    localparam logic [1:0] SCS_SECONDARY = 2'h1;
    localparam logic [3:0] FSEL_PLL = 4'he;
    localparam logic [3:0] FSEL_HF_31K = 4'h3;

    // config_clock_mode encodings
    localparam logic [2:0] MODE_LOW_POWER_CRYSTAL = 3'h0;
    localparam logic [2:0] MODE_CRYSTAL = 3'h1;
    localparam logic [2:0] MODE_HIGH_SPEED_CRYSTAL = 3'h2;
    localparam logic [2:0] MODE_INTERNAL_OSC_BLOCK = 3'h4;

    // timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int INT_WARM_NS = 2000;
    localparam int INT_WARM_CYC = (INT_WARM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PLL_LOCK_US = 2000;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000000) / CLK_PERIOD_PS;
    localparam int OST_COUNT = 1024;

    typedef enum logic [2:0] {SRC_PRI, SRC_SEC, SRC_HF, SRC_MF, SRC_LF} scsc_src_t;
    typedef enum logic [2:0] {ST_IDLE, ST_WARM, ST_FALL, ST_HOLD, ST_UPDATE} scsc_state_t;

endpackage

// file: hw/scsc_sync.sv
// Purpose: two flip-flop synchroniser for oscillator levels
// Assumes: inputs are asynchronous to core_clk_in
// Notes: only the second stage may be read outside this module
`timescale 1ns/1ps
module scsc_sync #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            meta_r <= '0;
            q_out <= '0;
        end
        else
        begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule // scsc_sync

// file: hw/scsc_ost.sv
// Purpose: start-up timer counting rising edges of an oscillator
// Assumes: lvl_in is already synchronised
// Notes: done_out holds until clear_in; clear wins over counting
`timescale 1ns/1ps
module scsc_ost #(
    parameter int COUNT = 1024
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // control
    input wire logic lvl_in,
    input wire logic run_in,
    input wire logic clear_in,
    output logic done_out
);
    localparam int CW = $clog2(COUNT + 1);
    logic [CW-1:0] cnt_r;
    logic lvl_q_r;

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            lvl_q_r <= 1'b0;
        else
            lvl_q_r <= lvl_in;
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt_r <= '0;
            done_out <= 1'b0;
        end
        else if (clear_in)
        begin
            cnt_r <= '0;
            done_out <= 1'b0;
        end
        else if (run_in && !done_out && lvl_in && !lvl_q_r)
        begin
            cnt_r <= cnt_r + 1'b1;
            done_out <= (cnt_r == CW'(COUNT - 1));
        end
    end
endmodule // scsc_ost

// file: hw/scsc_top.sv
// Purpose: system clock source selection with glitch-free handover and two-speed start-up
// Assumes: oscillators arrive as pins and are sampled at 40 MHz; config inputs are static
// Notes: sys_clk_out is a sampled image of the chosen oscillator, postscaling not modelled
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module scsc_top
    import scsc_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES = scsc_pkg::PLL_LOCK_CYC
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // register port
    input wire logic [scsc_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [scsc_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [scsc_pkg::DATA_W-1:0] reg_rdata_out,
    // configuration word
    input wire logic [2:0] config_clock_mode_in,
    input wire logic two_speed_enable_in,
    input wire logic config_pll_enable_in,
    // core status
    input wire logic sleep_in,
    input wire logic power_up_delay_timer_done_in,
    input wire logic secondary_ready_in,
    // oscillator pins
    input wire logic pri_osc_in,
    input wire logic sec_osc_in,
    input wire logic hf_osc_in,
    input wire logic mf_osc_in,
    input wire logic lf_osc_in,
    // system clock
    output logic sys_clk_out,
    output logic [2:0] active_src_out,
    output logic pll_enable_out,
    output logic switch_busy_out
);
    import scsc_pkg::*;

    localparam int WC = $clog2(PLL_LOCK_CYCLES + INT_WARM_CYC + 1);

    // control register
    logic sw_pll_r;
    logic [3:0] fsel_r;
    logic [1:0] scs_r;

    // switch state
    scsc_state_t state_r;
    scsc_src_t cur_src_r;
    scsc_src_t nxt_src_r;
    scsc_src_t tgt_src;
    scsc_src_t int_src;
    logic pll_on_r;
    logic nxt_pll_r;
    logic tgt_pll;
    logic [WC-1:0] warm_cnt_r;
    logic sys_clk_r;

    // status
    logic hf_act_r;
    logic mf_act_r;
    logic lf_act_r;
    logic pll_rdy_r;
    logic done_flag_r;

    // start-up timers
    logic por_wait_r;
    logic sleep_q_r;
    logic pri_run_r;
    logic pri_start;
    logic pri_done;
    logic sec_done;

    // oscillator levels, indexed by scsc_src_t
    logic [4:0] osc_s;
    logic [4:0] osc_q_r;
    logic [4:0] osc_rise;
    logic [4:0] osc_fall;

    logic crystal;
    logic two_speed;
    logic pll_en;
    logic pll_want;
    logic mismatch;
    logic warm_ok;

    scsc_sync #(
        .W(5)
    ) u_sync (
        .clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .d_in({lf_osc_in, mf_osc_in, hf_osc_in, sec_osc_in, pri_osc_in}),
        .q_out(osc_s)
    );

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            osc_q_r <= 5'h00;
        else
            osc_q_r <= osc_s;
    end

    assign osc_rise = osc_s & ~osc_q_r;
    assign osc_fall = ~osc_s & osc_q_r;

    // configuration decode
    assign crystal = (config_clock_mode_in == MODE_LOW_POWER_CRYSTAL) ||
                     (config_clock_mode_in == MODE_CRYSTAL) ||
                     (config_clock_mode_in == MODE_HIGH_SPEED_CRYSTAL);
    assign two_speed = two_speed_enable_in && (scs_r == SCS_CONFIG) && crystal;
    assign pll_en = config_pll_enable_in || sw_pll_r;
    assign pll_want = pll_en && (scs_r == SCS_CONFIG) &&
                      (config_clock_mode_in == MODE_INTERNAL_OSC_BLOCK) && (fsel_r == FSEL_PLL);

    // register writes; hardware never touches the source select field
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sw_pll_r <= FSEL_PLL_RST;
            fsel_r <= FSEL_RST;
            scs_r <= SCS_RST;
        end
        else if (reg_wr_in && reg_addr_in == OFS_CTRL)
        begin
            sw_pll_r <= reg_wdata_in[CTL_PLL_BIT];
            fsel_r <= reg_wdata_in[CTL_FSEL_LSB +: 4];
            scs_r <= reg_wdata_in[CTL_SCS_LSB +: 2];
        end
    end

    // register reads: data valid in the cycle after the strobe only
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            reg_rdata_out <= 8'h00;
        else if (reg_rd_in && reg_addr_in == OFS_CTRL)
            reg_rdata_out <= {sw_pll_r, fsel_r, 1'b0, scs_r};
        else if (reg_rd_in && reg_addr_in == OFS_STAT)
            reg_rdata_out <= {secondary_ready_in, pll_rdy_r, done_flag_r, hf_act_r,
                              1'b0, mf_act_r, lf_act_r, 1'b0};
        else
            reg_rdata_out <= 8'h00;
    end

    // primary start-up timer: armed after power-up delay and on each wake
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            por_wait_r <= 1'b1;
            sleep_q_r <= 1'b0;
        end
        else
        begin
            if (power_up_delay_timer_done_in)
                por_wait_r <= 1'b0;
            sleep_q_r <= sleep_in;
        end
    end

    assign pri_start = (por_wait_r && power_up_delay_timer_done_in) || (sleep_q_r && !sleep_in);

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            pri_run_r <= 1'b0;
        else if (sleep_in)
            pri_run_r <= 1'b0;
        else if (pri_start)
            pri_run_r <= crystal;
    end

    // sleep clears the count, so an aborted start-up never reports done
    scsc_ost #(
        .COUNT(OST_COUNT)
    ) u_ost_pri (
        .clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .lvl_in(osc_s[SRC_PRI]),
        .run_in(pri_run_r),
        .clear_in(sleep_in || pri_start),
        .done_out(pri_done)
    );

    scsc_ost #(
        .COUNT(OST_COUNT)
    ) u_ost_sec (
        .clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .lvl_in(osc_s[SRC_SEC]),
        .run_in(state_r == ST_WARM && nxt_src_r == SRC_SEC),
        .clear_in(state_r != ST_WARM),
        .done_out(sec_done)
    );

    // internal oscillator behind internal_freq_select
    always_comb
    begin
        if (fsel_r[3] || fsel_r == FSEL_HF_31K)
            int_src = SRC_HF;
        else if (fsel_r[3:1] == 3'h0)
            int_src = SRC_LF;
        else
            int_src = SRC_MF;
    end

    // source that the settings ask for right now
    always_comb
    begin
        if (scs_r == SCS_SECONDARY)
            tgt_src = SRC_SEC;
        else if (scs_r[1])
            tgt_src = int_src;
        else if (config_clock_mode_in == MODE_INTERNAL_OSC_BLOCK)
            tgt_src = int_src;
        else if (two_speed && !pri_done)
            tgt_src = int_src;
        else
            tgt_src = SRC_PRI;
    end

    assign tgt_pll = pll_want && (tgt_src == SRC_HF);
    // a frequency step inside the running oscillator is no source change unless it turns the PLL on or off
    assign mismatch = (tgt_src != cur_src_r) || (tgt_pll != pll_on_r);

    // warm-up finished: delay run out and, where needed, start-up timer expired
    always_comb
    begin
        if (warm_cnt_r != '0)
            warm_ok = 1'b0;
        else if (nxt_src_r == SRC_SEC)
            warm_ok = sec_done;
        else if (nxt_src_r == SRC_PRI && crystal)
            warm_ok = pri_done;
        else
            warm_ok = 1'b1;
    end

    // switch sequencer
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_r <= ST_IDLE;
            nxt_src_r <= SRC_MF;
            nxt_pll_r <= 1'b0;
            warm_cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (mismatch)
                    begin
                        nxt_src_r <= tgt_src;
                        nxt_pll_r <= tgt_pll;
                        state_r <= ST_WARM;
                        if (tgt_pll && !pll_on_r)
                            warm_cnt_r <= WC'(PLL_LOCK_CYCLES);
                        else if ((tgt_src == SRC_HF || tgt_src == SRC_MF) &&
                                 tgt_src != cur_src_r)
                            warm_cnt_r <= WC'(INT_WARM_CYC);
                        else
                            warm_cnt_r <= '0;
                    end
                end
                ST_WARM:
                begin
                    // abandon a stale request, e.g. a start-up cut short by sleep
                    if (tgt_src != nxt_src_r || tgt_pll != nxt_pll_r)
                        state_r <= ST_IDLE;
                    else if (warm_cnt_r != '0)
                        warm_cnt_r <= warm_cnt_r - 1'b1;
                    else if (warm_ok)
                        state_r <= ST_FALL;
                end
                ST_FALL:
                begin
                    if (osc_fall[cur_src_r])
                        state_r <= ST_HOLD;
                end
                ST_HOLD:
                begin
                    if (osc_rise[nxt_src_r])
                        state_r <= ST_UPDATE;
                end
                ST_UPDATE:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // active source changes only on the rising edge of the new clock
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cur_src_r <= SRC_MF;
            pll_on_r <= 1'b0;
        end
        else if (state_r == ST_HOLD && osc_rise[nxt_src_r])
        begin
            cur_src_r <= nxt_src_r;
            pll_on_r <= nxt_pll_r;
        end
    end

    // system clock image: low from the old falling edge to the new rising edge
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            sys_clk_r <= 1'b0;
        else if (state_r == ST_HOLD)
            sys_clk_r <= osc_rise[nxt_src_r];
        else
            sys_clk_r <= osc_s[cur_src_r];
    end

    // status follows the active clock one cycle after it takes over
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            hf_act_r <= 1'b0;
            mf_act_r <= 1'b1;
            lf_act_r <= 1'b0;
            pll_rdy_r <= 1'b0;
            done_flag_r <= 1'b0;
        end
        else if (state_r == ST_UPDATE)
        begin
            hf_act_r <= (cur_src_r == SRC_HF);
            mf_act_r <= (cur_src_r == SRC_MF);
            lf_act_r <= (cur_src_r == SRC_LF);
            pll_rdy_r <= pll_on_r;
            done_flag_r <= (cur_src_r == SRC_PRI);
        end
    end

    assign sys_clk_out = sys_clk_r;
    assign active_src_out = cur_src_r;
    assign pll_enable_out = pll_en;
    assign switch_busy_out = (state_r != ST_IDLE);

endmodule // scsc_top

// file: bench/scsc_osc_model.sv
// Purpose: oscillator pins and secondary ready level around the clock switch
// Assumes: every rate is well below half the core clock
// Notes: rates other than the primary's are unrelated so edges drift against the core clock; the primary period is 8 core periods
`timescale 1ns/1ps
module scsc_osc_model (
    // core clock
    input wire logic core_clk_in,
    // oscillator pins
    output logic pri_osc_out,
    output logic sec_osc_out,
    output logic hf_osc_out,
    output logic mf_osc_out,
    output logic lf_osc_out,
    // secondary readiness
    output logic secondary_ready_out
);
    int sec_edges = 0;

    // one process per pin, so no pin has two writers
    initial
    begin
        {pri_osc_out, sec_osc_out, hf_osc_out, mf_osc_out, lf_osc_out} = 5'h00;
        fork
            forever #100 pri_osc_out = ~pri_osc_out;
            forever #190 sec_osc_out = ~sec_osc_out;
            forever #70 hf_osc_out = ~hf_osc_out;
            forever #130 mf_osc_out = ~mf_osc_out;
            forever #230 lf_osc_out = ~lf_osc_out;
        join
    end
    always @(posedge sec_osc_out) sec_edges++;
    // crystal needs some swings before it reports ready
    always @(posedge core_clk_in) secondary_ready_out <= (sec_edges >= 64);
endmodule // scsc_osc_model

// file: bench/scsc_top_sva.sv
// Purpose: port-level assertions for the clock switch control
// Assumes: status reads are only judged when no switch is under way
// Notes: bound into scsc_top
`timescale 1ns/1ps
module scsc_top_sva
    import scsc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic [scsc_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [scsc_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic config_pll_enable_in,
    input wire logic sleep_in,
    input wire logic sys_clk_out,
    input wire logic [2:0] active_src_out,
    input wire logic pll_enable_out,
    input wire logic switch_busy_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    logic st_rd;
    assign st_rd = reg_rd_in && reg_addr_in == OFS_STAT && !switch_busy_out;

    a_pll_forced: assert property (config_pll_enable_in |-> pll_enable_out)
        else $error("pll enable dropped while forced");
    a_switch_done: assert property ($changed(active_src_out) |->
        switch_busy_out ##1 !switch_busy_out)
        else $error("switch did not finish one cycle after source change");
    a_clk_held_low: assert property ($changed(active_src_out) |-> !$past(sys_clk_out))
        else $error("system clock not held low at handover");
    a_done_src: assert property (st_rd |=>
        reg_rdata_out[STAT_DONE_BIT] == ($past(active_src_out) == SRC_PRI))
        else $error("done flag disagrees with active source");
    a_done_not_sec: assert property (st_rd && active_src_out == SRC_SEC |=>
        !reg_rdata_out[STAT_DONE_BIT])
        else $error("done flag set while on secondary");
    a_int_status: assert property (st_rd |=>
        {reg_rdata_out[STAT_HF_BIT], reg_rdata_out[STAT_MF_BIT], reg_rdata_out[STAT_LF_BIT]} ==
        {$past(active_src_out) == SRC_HF, $past(active_src_out) == SRC_MF,
         $past(active_src_out) == SRC_LF})
        else $error("internal oscillator status wrong");
    a_sleep_no_pri: assert property (sleep_in && $changed(active_src_out) |->
        active_src_out != SRC_PRI)
        else $error("moved to primary while sleeping");
    a_pll_flag_src: assert property (st_rd |=>
        !reg_rdata_out[STAT_PLL_BIT] || $past(active_src_out) == SRC_HF)
        else $error("pll ready without high internal source");
endmodule // scsc_top_sva

bind scsc_top scsc_top_sva u_sva (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .config_pll_enable_in(config_pll_enable_in), .sleep_in(sleep_in),
    .sys_clk_out(sys_clk_out), .active_src_out(active_src_out),
    .pll_enable_out(pll_enable_out), .switch_busy_out(switch_busy_out));

// file: bench/tb_top.sv
// Purpose: self-checking bench for the clock switch control
// Assumes: short pll lock count; oscillators from the model
// Notes: config inputs only change while reset is held
`timescale 1ns/1ps
module tb_top;
    import scsc_pkg::*;
    logic core_clk_in, arst_n_in, reg_wr_in, reg_rd_in, two_speed_enable_in;
    logic config_pll_enable_in, sleep_in, power_up_delay_timer_done_in, sec_rdy, sys_clk_out;
    logic pll_enable_out, switch_busy_out;
    logic pri, sec, hf, mf, lf;
    logic [1:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out;
    logic [2:0] config_clock_mode_in, active_src_out;
    int errors, n_compared, n;

    scsc_top #(.PLL_LOCK_CYCLES(20)) u_dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .config_clock_mode_in(config_clock_mode_in), .two_speed_enable_in(two_speed_enable_in),
        .config_pll_enable_in(config_pll_enable_in), .sleep_in(sleep_in),
        .power_up_delay_timer_done_in(power_up_delay_timer_done_in), .secondary_ready_in(sec_rdy), .pri_osc_in(pri),
        .sec_osc_in(sec), .hf_osc_in(hf), .mf_osc_in(mf), .lf_osc_in(lf),
        .sys_clk_out(sys_clk_out), .active_src_out(active_src_out),
        .pll_enable_out(pll_enable_out), .switch_busy_out(switch_busy_out));
    scsc_osc_model u_osc (.core_clk_in(core_clk_in), .pri_osc_out(pri), .sec_osc_out(sec),
        .hf_osc_out(hf), .mf_osc_out(mf), .lf_osc_out(lf), .secondary_ready_out(sec_rdy));

    initial
    begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    task automatic final_report();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic timeout(input string msg);
        errors++;
        $display("FAIL %0t timeout %s", $time, msg);
        final_report();
    endtask

    function automatic logic [7:0] stat(logic s, logic p, logic d, logic [2:0] src);
        return {s, p, d, src == SRC_HF, 1'b0, src == SRC_MF, src == SRC_LF, 1'b0};
    endfunction

    task automatic do_reset(input logic [2:0] m, input logic ts, input logic pe);
        @(posedge core_clk_in);
        arst_n_in <= 1'b0;
        config_clock_mode_in <= m;
        two_speed_enable_in <= ts;
        config_pll_enable_in <= pe;
        repeat (4) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string msg);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp, msg);
    endtask

    // firmware style: poll a status bit, bounded
    task automatic poll(input int b, input logic v);
        logic [7:0] d;
        for (n = 0; n < 2000; n++)
        begin
            rd(OFS_STAT, d);
            if (d[b] === v) break;
        end
        if (n >= 2000) timeout("poll");
    endtask

    task automatic wait_src(input logic [2:0] s);
        for (n = 0; n < 40000; n++)
        begin
            @(posedge core_clk_in);
            #1;
            if (active_src_out === s && switch_busy_out === 1'b0) break;
        end
        if (n >= 40000) timeout("switch");
    endtask

    task automatic t_reset_vals();
        do_reset(MODE_INTERNAL_OSC_BLOCK, 1'b0, 1'b0);
        rd_chk(OFS_CTRL, 8'h38, "ctrl reset");
        rd_chk(OFS_STAT, stat(1'b0, 1'b0, 1'b0, SRC_MF), "stat reset");
        wr(OFS_STAT, 8'hff);
        rd_chk(OFS_STAT, stat(1'b0, 1'b0, 1'b0, SRC_MF), "stat read only");
        rd_chk(2'h2, 8'h00, "unmapped");
    endtask

    task automatic t_internal();
        logic busy_seen;
        wr(OFS_CTRL, 8'h02);
        wait_src(SRC_LF);
        rd_chk(OFS_STAT, stat(1'b0, 1'b0, 1'b0, SRC_LF), "lf status");
        wr(OFS_CTRL, 8'h7a);
        wait_src(SRC_HF);
        chk({7'h0, n >= INT_WARM_CYC - 2}, 8'h01, "hf warm delay");
        busy_seen = 1'b0;
        wr(OFS_CTRL, 8'h6a);
        repeat (20)
        begin
            @(posedge core_clk_in);
            #1 busy_seen |= switch_busy_out;
        end
        chk({7'h0, busy_seen}, 8'h00, "same source no switch");
        wr(OFS_CTRL, 8'h3a);
        wait_src(SRC_MF);
    endtask

    task automatic t_secondary();
        poll(STAT_SEC_BIT, 1'b1);
        wr(OFS_CTRL, 8'h39);
        wait_src(SRC_SEC);
        chk({7'h0, n >= 15000}, 8'h01, "secondary start-up count");
        rd_chk(OFS_STAT, stat(1'b1, 1'b0, 1'b0, SRC_SEC), "sec status");
        wr(OFS_CTRL, 8'hf0);
        wait_src(SRC_HF);
        rd_chk(OFS_STAT, stat(1'b1, 1'b1, 1'b0, SRC_HF), "pll on");
        wr(OFS_CTRL, 8'h70);
        poll(STAT_PLL_BIT, 1'b0);
        rd_chk(OFS_CTRL, 8'h70, "ctrl kept");
    endtask

    task automatic t_two_speed();
        power_up_delay_timer_done_in <= 1'b0;
        do_reset(MODE_CRYSTAL, 1'b1, 1'b0);
        rd_chk(OFS_STAT, stat(1'b1, 1'b0, 1'b0, SRC_MF), "internal first");
        // power-up delay still running: the start-up count must not begin yet
        repeat (1000) @(posedge core_clk_in);
        #1 chk({5'h0, active_src_out}, {5'h0, SRC_MF}, "held by power-up delay");
        @(posedge core_clk_in) power_up_delay_timer_done_in <= 1'b1;
        wait_src(SRC_PRI);
        chk({7'h0, n >= 8000}, 8'h01, "primary count");
        rd_chk(OFS_STAT, stat(1'b1, 1'b0, 1'b1, SRC_PRI), "on primary");
        rd_chk(OFS_CTRL, 8'h38, "select untouched");
        // long enough for the move back to internal to finish while asleep
        @(posedge core_clk_in) sleep_in <= 1'b1;
        repeat (150) @(posedge core_clk_in);
        sleep_in <= 1'b0;
        wait_src(SRC_MF);
        repeat (100) @(posedge core_clk_in);
        sleep_in <= 1'b1;
        repeat (50) @(posedge core_clk_in);
        rd_chk(OFS_STAT, stat(1'b1, 1'b0, 1'b0, SRC_MF), "aborted count");
        @(posedge core_clk_in) sleep_in <= 1'b0;
        wait_src(SRC_PRI);
    endtask

    task automatic t_ext_clock();
        logic hi_seen;
        logic lo_seen;
        // external clock mode skips the timer, so two-speed must stay off
        do_reset(3'h3, 1'b1, 1'b1);
        wait_src(SRC_PRI);
        chk({7'h0, n < 200}, 8'h01, "no start-up count");
        hi_seen = 1'b0;
        lo_seen = 1'b0;
        repeat (40)
        begin
            @(posedge core_clk_in);
            #1;
            hi_seen |= sys_clk_out;
            lo_seen |= !sys_clk_out;
        end
        chk({6'h0, hi_seen, lo_seen}, 8'h03, "system clock follows primary");
        chk({7'h0, pll_enable_out}, 8'h01, "pll forced");
        rd_chk(OFS_STAT, stat(1'b1, 1'b0, 1'b1, SRC_PRI), "ext status");
    endtask

    initial
    begin
        errors = 0;
        n_compared = 0;
        arst_n_in = 1'b0;
        {reg_wr_in, reg_rd_in, sleep_in, two_speed_enable_in, config_pll_enable_in} = 5'h00;
        power_up_delay_timer_done_in = 1'b1;
        reg_addr_in = 2'h0;
        reg_wdata_in = 8'h00;
        config_clock_mode_in = MODE_INTERNAL_OSC_BLOCK;
        t_reset_vals();
        t_internal();
        t_secondary();
        t_two_speed();
        t_ext_clock();
        final_report();
    end
endmodule // tb_top
